// ---- hdl/nvm_move_pkg.sv ----
/*
  Constants for the data-memory move steering and on-chip data store write control.
  Assumes a 100 MHz core clock and a 32-bit APB register bus.
*/
package nvm_move_pkg;

  // ----------------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_MHZ         = 100;
  localparam int unsigned PROG_TIME_US    = 4000;  // self-timed programming, 4 ms
  localparam int unsigned BOD_DELAY_US    = 2000;  // hold-off after brown-out, 2 ms
  localparam int unsigned PROG_CYCLES_DEF = PROG_TIME_US * CLK_MHZ;
  localparam int unsigned BOD_CYCLES_DEF  = BOD_DELAY_US * CLK_MHZ;

  // ----------------------------------------------------------------------
  // memory geometry
  // ----------------------------------------------------------------------
  localparam int unsigned ADDR_W      = 16;
  localparam int unsigned NVM_ADDR_W  = 11;
  localparam int unsigned PAGE_W      = 5;
  localparam int unsigned PAGE_BYTES  = 32;
  localparam logic [15:0] NVM_LIMIT   = 16'h0800;  // 2K bytes on chip
  localparam logic [7:0]  MSB_FLIP    = 8'h80;

  // ----------------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_PTR0    = 8'h04;
  localparam logic [7:0] OFS_PTR1    = 8'h08;
  localparam logic [7:0] OFS_STATUS  = 8'h0C;
  localparam logic [7:0] OFS_MASK    = 8'h10;

  // ----------------------------------------------------------------------
  // control register fields
  // ----------------------------------------------------------------------
  localparam int unsigned BIT_LOAD_ONLY = 5;
  localparam int unsigned BIT_WR_EN     = 4;
  localparam int unsigned BIT_INT_SEL   = 3;
  localparam int unsigned BIT_BANK_SEL  = 2;
  localparam int unsigned BIT_READY     = 1;
  localparam int unsigned BIT_WI_N      = 0;
  localparam logic [3:0]  CTRL_RESET    = 4'h0;   // writable bits 5..2

  // ----------------------------------------------------------------------
  // interrupt status fields
  // ----------------------------------------------------------------------
  localparam int unsigned EV_W          = 3;
  localparam int unsigned EV_PROG_DONE  = 0;
  localparam int unsigned EV_PROG_ABORT = 1;
  localparam int unsigned EV_BROWNOUT   = 2;
  localparam logic [2:0]  EV_RESET      = 3'h0;

  // ----------------------------------------------------------------------
  // move sequencer states
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    MV_IDLE = 2'b00,
    MV_EXT  = 2'b01,
    MV_NVM  = 2'b10
  } move_state_t;

endpackage

// ---- hdl/cycle_countdown.sv ----
/*
  Loadable down-counter used as a one-shot delay.
  Assumes start and abort are synchronous one-cycle or level requests.
*/
`timescale 1ns/1ps
module cycle_countdown #(
  parameter int unsigned COUNT = 4,
  localparam int unsigned W    = $clog2(COUNT + 1)
) (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic resetn,
  // control
  input  wire logic start,
  input  wire logic abort,
  // state
  output logic      busy,
  output logic      done
);

  logic [W-1:0] cnt_reg;

  // ----------------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------------
  // abort wins over a running count, start reloads
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      cnt_reg <= '0;
    end else if (start) begin
      cnt_reg <= W'(COUNT);
    end else if (abort) begin
      cnt_reg <= '0;
    end else if (cnt_reg != '0) begin
      cnt_reg <= cnt_reg - W'(1);
    end
  end

  // last cycle of the count
  assign busy = (cnt_reg != '0);
  assign done = (cnt_reg == W'(1)) && !abort && !start;

endmodule

// ---- hdl/nvm_move_control.sv ----
/*
  Steers pointer-based data moves to the on-chip data store or to external
  memory, buffers store writes a page at a time, times programming and
  blocks it on low supply. Registers sit on APB.
  Assumes all inputs are synchronous to core_clk and the cell array is outside.
*/
// Overview of operation
// - select set and address below 2K sends the move to the on-chip store
// - select clear or address 2K and up sends the move to external memory
// - bank select 0 uses pointer bank zero, 1 uses bank one
// - ready flag reads low while a programming cycle runs
// - ready flag is set by hardware when programming ends
// - ready falls only when programming truly starts, after the move
// - read-only write-inhibit bit is cleared while supply is too low
// - with inhibit cleared, running programming aborts and none starts
// - brown-out activates the write inhibit and blocks programming
// - after brown-out ends, a 2 ms delay keeps programming blocked
// - brown-out never produces a system reset; it inhibits writes and flags a status event
// - at power-up, execution waits until brown-out has first cleared
// - load-only set fills the page buffer; clear programs the whole page
// - store read during programming returns written byte with MSB flipped
// - one programming cycle takes 4 ms for one byte or a full page
`timescale 1ns/1ps
module nvm_move_control #(
  parameter int unsigned PROG_CYCLES = nvm_move_pkg::PROG_CYCLES_DEF,
  parameter int unsigned BOD_CYCLES  = nvm_move_pkg::BOD_CYCLES_DEF
) (
  // clock and reset
  input  wire logic                              core_clk,
  input  wire logic                              resetn,
  // apb slave
  input  wire logic [7:0]                        paddr,
  input  wire logic                              psel,
  input  wire logic                              penable,
  input  wire logic                              pwrite,
  input  wire logic [31:0]                       pwdata,
  output logic      [31:0]                       prdata,
  output logic                                   pready,
  output logic                                   pslverr,
  // core move port
  input  wire logic                              move_valid,
  input  wire logic                              move_write,
  input  wire logic [7:0]                        move_wdata,
  output logic                                   move_done,
  output logic      [7:0]                        move_rdata,
  // external data memory
  output logic                                   ext_req,
  output logic                                   ext_write,
  output logic      [nvm_move_pkg::ADDR_W-1:0]   ext_addr,
  output logic      [7:0]                        ext_wdata,
  input  wire logic                              ext_ack,
  input  wire logic [7:0]                        ext_rdata,
  // on-chip cell array
  output logic      [nvm_move_pkg::NVM_ADDR_W-1:0] nvm_addr,
  input  wire logic [7:0]                        nvm_rdata,
  output logic                                   prog_active,
  output logic      [nvm_move_pkg::NVM_ADDR_W-nvm_move_pkg::PAGE_W-1:0] prog_page,
  input  wire logic [nvm_move_pkg::PAGE_W-1:0]   buf_index,
  output logic      [7:0]                        buf_data,
  output logic                                   buf_valid,
  // supply detectors
  input  wire logic                              brownout_detector,
  input  wire logic                              low_supply,
  // status
  output logic                                   write_inhibit_n,
  output logic                                   cpu_run,
  output logic                                   irq
);
  import nvm_move_pkg::*;

  localparam int unsigned PG_W = NVM_ADDR_W - PAGE_W;

  // routing decision of a pointer move
  function automatic logic goes_internal(input logic sel, input logic [ADDR_W-1:0] a);
    goes_internal = sel && (a < NVM_LIMIT);
  endfunction

  // ----------------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------------
  logic              load_only_select;
  logic              nvm_write_enable;
  logic              internal_nvm_select;
  logic              pointer_bank_select;
  logic              ready_not_busy;
  logic [ADDR_W-1:0] pointer_bank_zero;
  logic [ADDR_W-1:0] pointer_bank_one;
  logic [EV_W-1:0]   ev_status_reg;
  logic [EV_W-1:0]   ev_mask_reg;
  logic [EV_W-1:0]   ev_set;
  logic              apb_done;
  logic              apb_wr;
  logic              status_rd;
  logic              addr_ok;
  logic [31:0]       rd_value;
  move_state_t       mv_state;
  logic [ADDR_W-1:0] data_pointer;
  logic              to_nvm;
  logic [7:0]        page_buf [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] page_valid;
  logic [PG_W-1:0]   buf_page_reg;
  logic              prog_req_reg;
  logic              prog_busy;
  logic              prog_fin;
  logic              prog_abort;
  logic              bod_prev_reg;
  logic              bod_fall;
  logic              bod_busy;
  logic              buf_hit;

  assign data_pointer = pointer_bank_select ? pointer_bank_one : pointer_bank_zero;
  assign to_nvm       = goes_internal(internal_nvm_select, data_pointer);

  // ----------------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------------
  assign apb_done  = psel && penable && pready;
  assign apb_wr    = apb_done && pwrite && !pslverr;
  assign status_rd = apb_done && !pwrite && (paddr == OFS_STATUS);
  assign addr_ok   = (paddr == OFS_CONTROL) || (paddr == OFS_PTR0) || (paddr == OFS_PTR1)
                  || (paddr == OFS_STATUS) || (paddr == OFS_MASK);

  // read mux, reserved bits zero
  always_comb begin
    rd_value = 32'h0000_0000;
    unique case (paddr)
      OFS_CONTROL: rd_value = {26'h0, load_only_select, nvm_write_enable, internal_nvm_select,
                               pointer_bank_select, ready_not_busy, write_inhibit_n};
      OFS_PTR0:    rd_value = {16'h0, pointer_bank_zero};
      OFS_PTR1:    rd_value = {16'h0, pointer_bank_one};
      OFS_STATUS:  rd_value = {29'h0, ev_status_reg};
      OFS_MASK:    rd_value = {29'h0, ev_mask_reg};
      default:     rd_value = 32'h0000_0000;
    endcase
  end

  // one access cycle: answer prepared in setup
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel && !penable && !pready;
      pslverr <= psel && !penable && !addr_ok;
      prdata  <= (psel && !penable && !pwrite) ? rd_value : 32'h0000_0000;
    end
  end

  // software-written control and pointers
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      {load_only_select, nvm_write_enable, internal_nvm_select, pointer_bank_select} <= CTRL_RESET;
      pointer_bank_zero <= 16'h0000;
      pointer_bank_one  <= 16'h0000;
      ev_mask_reg       <= EV_RESET;
    end else if (apb_wr) begin
      if (paddr == OFS_CONTROL) begin
        load_only_select    <= pwdata[BIT_LOAD_ONLY];
        nvm_write_enable    <= pwdata[BIT_WR_EN];
        internal_nvm_select <= pwdata[BIT_INT_SEL];
        pointer_bank_select <= pwdata[BIT_BANK_SEL];
      end
      if (paddr == OFS_PTR0) begin
        pointer_bank_zero <= pwdata[ADDR_W-1:0];
      end
      if (paddr == OFS_PTR1) begin
        pointer_bank_one <= pwdata[ADDR_W-1:0];
      end
      if (paddr == OFS_MASK) begin
        ev_mask_reg <= pwdata[EV_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------------
  // interrupts
  // ----------------------------------------------------------------------
  assign ev_set = {bod_fall ? 1'b0 : (brownout_detector && !bod_prev_reg), prog_abort, prog_fin};

  // sticky events, read clears, a new event wins
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      ev_status_reg <= EV_RESET;
      irq           <= 1'b0;
    end else begin
      ev_status_reg <= (status_rd ? EV_RESET : ev_status_reg) | ev_set;
      irq           <= |(((status_rd ? EV_RESET : ev_status_reg) | ev_set) & ev_mask_reg);
    end
  end

  // ----------------------------------------------------------------------
  // supply supervision
  // ----------------------------------------------------------------------
  assign bod_fall = bod_prev_reg && !brownout_detector;

  cycle_countdown #(
    .COUNT (BOD_CYCLES)
  ) bod_delay (
    .core_clk (core_clk),
    .resetn   (resetn),
    .start    (bod_fall),
    .abort    (brownout_detector),
    .busy     (bod_busy),
    .done     ()
  );

  // inhibit from digital detector levels only, never a reset
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      bod_prev_reg    <= 1'b1;
      write_inhibit_n <= 1'b0;
      cpu_run         <= 1'b0;
    end else begin
      bod_prev_reg    <= brownout_detector;
      write_inhibit_n <= !(brownout_detector || low_supply || bod_busy || bod_fall);
      if (!brownout_detector) begin
        cpu_run <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // move sequencer
  // ----------------------------------------------------------------------
  assign buf_hit = page_valid[nvm_addr[PAGE_W-1:0]] && (nvm_addr[NVM_ADDR_W-1:PAGE_W] == buf_page_reg);

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      mv_state     <= MV_IDLE;
      move_done    <= 1'b0;
      move_rdata   <= 8'h00;
      ext_req      <= 1'b0;
      ext_write    <= 1'b0;
      ext_addr     <= 16'h0000;
      ext_wdata    <= 8'h00;
      nvm_addr     <= '0;
      prog_req_reg <= 1'b0;
    end else begin
      move_done    <= 1'b0;
      prog_req_reg <= 1'b0;
      unique case (mv_state)
        MV_IDLE: begin
          if (move_valid && !move_done && !to_nvm) begin  // no retake in the done cycle
            ext_req   <= 1'b1;
            ext_write <= move_write;
            ext_addr  <= data_pointer;
            ext_wdata <= move_wdata;
            mv_state  <= MV_EXT;
          end else if (move_valid && !move_done) begin
            nvm_addr <= data_pointer[NVM_ADDR_W-1:0];
            mv_state <= MV_NVM;
            if (move_write && nvm_write_enable && ready_not_busy && write_inhibit_n) begin
              prog_req_reg <= !load_only_select;
            end
          end
        end
        MV_EXT: begin
          if (ext_ack) begin
            ext_req    <= 1'b0;
            move_rdata <= ext_rdata;
            move_done  <= 1'b1;
            mv_state   <= MV_IDLE;
          end
        end
        MV_NVM: begin
          move_rdata <= (prog_active && buf_hit) ? (page_buf[nvm_addr[PAGE_W-1:0]] ^ MSB_FLIP)
                                                 : nvm_rdata;
          move_done  <= 1'b1;
          mv_state   <= MV_IDLE;
        end
        default: mv_state <= MV_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // page buffer
  // ----------------------------------------------------------------------
  // loads land while idle; buffer empties when programming ends
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      page_valid   <= '0;
      buf_page_reg <= '0;
      buf_data     <= 8'h00;
      buf_valid    <= 1'b0;
    end else begin
      if (prog_fin || prog_abort) begin
        page_valid <= '0;
      end else if (mv_state == MV_IDLE && move_valid && !move_done && move_write && to_nvm
                   && nvm_write_enable && ready_not_busy && write_inhibit_n) begin
        if (data_pointer[NVM_ADDR_W-1:PAGE_W] != buf_page_reg) begin
          page_valid <= '0;
        end
        page_valid[data_pointer[PAGE_W-1:0]] <= 1'b1;
        buf_page_reg <= data_pointer[NVM_ADDR_W-1:PAGE_W];
      end
      buf_data  <= page_buf[buf_index];
      buf_valid <= page_valid[buf_index];
    end
  end

  // byte storage, no reset needed for data
  always_ff @(posedge core_clk) begin
    if (mv_state == MV_IDLE && move_valid && !move_done && move_write && to_nvm
        && nvm_write_enable && ready_not_busy && write_inhibit_n) begin
      page_buf[data_pointer[PAGE_W-1:0]] <= move_wdata;
    end
  end

  // ----------------------------------------------------------------------
  // programming cycle
  // ----------------------------------------------------------------------
  assign prog_abort = prog_active && !write_inhibit_n;

  cycle_countdown #(
    .COUNT (PROG_CYCLES)
  ) prog_timer (
    .core_clk (core_clk),
    .resetn   (resetn),
    .start    (prog_req_reg && write_inhibit_n && !prog_active),
    .abort    (prog_abort),
    .busy     (prog_busy),
    .done     (prog_fin)
  );

  // ready falls at the real start, rises at finish or abort
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      prog_active    <= 1'b0;
      ready_not_busy <= 1'b1;
      prog_page      <= '0;
    end else if (prog_abort || prog_fin) begin
      prog_active    <= 1'b0;
      ready_not_busy <= 1'b1;
    end else if (prog_req_reg && write_inhibit_n && !prog_active) begin
      prog_active    <= 1'b1;
      ready_not_busy <= 1'b0;
      prog_page      <= buf_page_reg;
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  sequence s_move_taken;
    mv_state == MV_IDLE && move_valid && !move_done;
  endsequence

  sequence s_bod_released;
    $fell(brownout_detector) ##1 !brownout_detector;
  endsequence

  AST_ROUTE_NVM: assert property (@(posedge core_clk) disable iff (!resetn)
    s_move_taken ##0 to_nvm |=> !ext_req && mv_state == MV_NVM ##1 move_done)
    else $error("internal move reached external memory");

  AST_ROUTE_EXT: assert property (@(posedge core_clk) disable iff (!resetn)
    s_move_taken ##0 !to_nvm |=> ext_req && ext_addr == $past(data_pointer))
    else $error("external move not issued");

  AST_BANK: assert property (@(posedge core_clk) disable iff (!resetn)
    s_move_taken ##0 !to_nvm |=>
      ext_addr == ($past(pointer_bank_select) ? $past(pointer_bank_one) : $past(pointer_bank_zero)))
    else $error("wrong pointer bank");

  AST_BUSY_LOW: assert property (@(posedge core_clk) disable iff (!resetn)
    prog_active |-> !ready_not_busy && prog_busy)
    else $error("ready high during programming");

  AST_READY_SET: assert property (@(posedge core_clk) disable iff (!resetn)
    prog_fin |=> ready_not_busy && !prog_active)
    else $error("ready not set at finish");

  AST_START: assert property (@(posedge core_clk) disable iff (!resetn)
    s_move_taken ##0 (to_nvm && move_write && nvm_write_enable && !load_only_select
      && ready_not_busy && write_inhibit_n && !low_supply && !brownout_detector)
      |=> ready_not_busy ##1 !ready_not_busy)
    else $error("ready timing at start wrong");

  AST_ABORT: assert property (@(posedge core_clk) disable iff (!resetn)
    !write_inhibit_n |=> !prog_active)
    else $error("programming runs while inhibited");

  AST_BOD: assert property (@(posedge core_clk) disable iff (!resetn)
    brownout_detector |=> !write_inhibit_n)
    else $error("brown-out did not inhibit");

  AST_BOD_HOLD: assert property (@(posedge core_clk) disable iff (!resetn)
    s_bod_released |-> !write_inhibit_n [*8])
    else $error("inhibit released before delay");

  AST_RUN: assert property (@(posedge core_clk) disable iff (!resetn)
    $rose(cpu_run) |-> !$past(brownout_detector))
    else $error("execution started during brown-out");

  AST_MSB: assert property (@(posedge core_clk) disable iff (!resetn)
    mv_state == MV_NVM && prog_active && buf_hit
      |=> move_done && move_rdata == (page_buf[nvm_addr[PAGE_W-1:0]] ^ MSB_FLIP))
    else $error("busy read not complemented");

endmodule

// ---- testbench/ext_mem_model.sv ----
/*
  External data memory partner: answers each move request after lat cycles.
  Assumes one request at a time, held by the design until acknowledged.
*/
`timescale 1ns/1ps
module ext_mem_model (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        resetn,
  // request side
  input  wire logic        ext_req,
  input  wire logic [15:0] ext_addr,
  input  wire logic [3:0]  lat,
  output logic             ext_ack,
  output logic      [7:0]  ext_rdata,
  // observation
  output logic      [15:0] last_addr,
  output logic      [7:0]  hits
);
  logic [3:0] wait_cnt;
  logic       fire;

  // answer once the wait count reaches lat
  assign fire = ext_req && !ext_ack && (wait_cnt == lat);

  // ack pulse, latency count and access log
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      ext_ack   <= 1'b0;
      wait_cnt  <= 4'h0;
      hits      <= 8'h00;
      last_addr <= 16'h0000;
    end else begin
      ext_ack   <= fire;
      wait_cnt  <= (ext_req && !ext_ack && !fire) ? wait_cnt + 4'h1 : 4'h0;
      hits      <= fire ? hits + 8'h01 : hits;
      last_addr <= fire ? ext_addr : last_addr;
    end
  end

  // data is good only in the ack cycle; it toggles otherwise
  always_ff @(posedge core_clk) begin
    ext_rdata <= !resetn ? 8'h00 : (fire ? (ext_addr[7:0] ^ 8'hC3) : ~ext_rdata);
  end
endmodule

// ---- testbench/nvm_move_control_tb.sv ----
/*
  Self-checking bench for nvm_move_control: steering, programming, supply.
  Assumes short programming and hold-off counts and the ext_mem_model partner.
*/
`timescale 1ns/1ps
module nvm_move_control_tb;
  import nvm_move_pkg::*;
  localparam int PROG = 20;
  localparam int BODC = 10;
  typedef struct packed {
    logic [7:0]  ctrl;
    logic        ext;
    logic [15:0] addr;
    logic [7:0]  data;
  } row_t;
  row_t rows [4] = '{'{8'h08, 1'b0, 16'h0000, 8'h5A}, '{8'h0C, 1'b1, 16'h0800, 8'hC3},
                     '{8'h00, 1'b1, 16'h07FF, 8'h3C}, '{8'h04, 1'b1, 16'h0800, 8'hC3}};
  logic        core_clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00, move_wdata = 8'h00, nvm_rdata = 8'h5A, hits;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        move_valid = 1'b0, move_write = 1'b0, brownout_detector = 1'b0;
  logic        low_supply = 1'b0, pready, pslverr, move_done, ext_req, ext_ack, err;
  logic        write_inhibit_n, cpu_run, irq, buf_valid;
  logic [7:0]  move_rdata, ext_rdata, h0, mr, buf_data;
  logic [5:0]  prog_page;
  logic [15:0] ext_addr, last_addr;
  logic [4:0]  buf_index = 5'h1F;
  logic [3:0]  lat = 4'h0;
  int          bad_count = 0, checks = 0;

  // core clock, 100 MHz
  always #5 core_clk = ~core_clk;

  nvm_move_control #(.PROG_CYCLES(PROG), .BOD_CYCLES(BODC)) nvm_move_control_i (
    .core_clk(core_clk), .resetn(resetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .move_valid(move_valid), .move_write(move_write), .move_wdata(move_wdata),
    .move_done(move_done), .move_rdata(move_rdata), .ext_req(ext_req), .ext_write(),
    .ext_addr(ext_addr), .ext_wdata(), .ext_ack(ext_ack), .ext_rdata(ext_rdata), .nvm_addr(),
    .nvm_rdata(nvm_rdata), .prog_active(), .prog_page(prog_page), .buf_index(buf_index),
    .buf_data(buf_data), .buf_valid(buf_valid), .brownout_detector(brownout_detector),
    .low_supply(low_supply),
    .write_inhibit_n(write_inhibit_n), .cpu_run(cpu_run), .irq(irq));

  ext_mem_model ext_mem_model_i (
    .core_clk(core_clk), .resetn(resetn), .ext_req(ext_req), .ext_addr(ext_addr), .lat(lat),
    .ext_ack(ext_ack), .ext_rdata(ext_rdata), .last_addr(last_addr), .hits(hits));

  // verdict and end of run
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // compare and report
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one apb transfer, held until pready
  task automatic apb(input logic [7:0] a, input logic wr, input logic [31:0] wd);
    int n;
    @(posedge core_clk);
    paddr <= a;
    pwrite <= wr;
    pwdata <= wd;
    psel <= 1'b1;
    @(posedge core_clk);
    penable <= 1'b1;
    for (n = 0; n < 20 && pready !== 1'b1; n++) @(posedge core_clk);
    if (n == 20) begin
      chk("apb wait", 0, 1);
      tally_and_finish();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // one core move, held until move_done
  task automatic mv(input logic wr, input logic [7:0] wd);
    int n;
    @(posedge core_clk);
    move_valid <= 1'b1;
    move_write <= wr;
    move_wdata <= wd;
    @(posedge core_clk);
    for (n = 0; n < 40 && move_done !== 1'b1; n++) @(posedge core_clk);
    if (n == 40) begin
      chk("move wait", 0, 1);
      tally_and_finish();
    end
    mr = move_rdata;
    move_valid <= 1'b0;
  endtask

  // hang guard
  initial begin
    repeat (5000) @(posedge core_clk);
    chk("run time", 0, 1);
    tally_and_finish();
  end

  initial begin
    repeat (3) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (2) @(posedge core_clk);
    chk("inhibit after reset", write_inhibit_n, 0);
    repeat (BODC + 4) @(posedge core_clk);
    apb(OFS_CONTROL, 1'b0, 0);
    chk("control reset", rd, 32'h3);
    chk("cpu run", cpu_run, 1);
    apb(OFS_PTR0, 1'b1, 32'h07FF);
    apb(OFS_PTR1, 1'b1, 32'h0800);
    // steering table, partner latency varied per row
    for (int i = 0; i < 4; i++) begin
      lat <= 4'(i * 3);
      apb(OFS_CONTROL, 1'b1, 32'(rows[i].ctrl));
      h0 = hits;
      mv(1'b0, 8'h00);
      chk("move data", mr, rows[i].data);
      chk("ext count", hits - h0, 8'(rows[i].ext));
      if (rows[i].ext) chk("ext addr", last_addr, rows[i].addr);
    end
    apb(OFS_MASK, 1'b1, 32'h7);
    apb(OFS_CONTROL, 1'b1, 32'h18);
    mv(1'b1, 8'h11);
    apb(OFS_CONTROL, 1'b0, 0);
    chk("busy control", rd, 32'h19);
    mv(1'b0, 8'h00);
    chk("busy read", mr, 32'h91);
    repeat (PROG + 4) @(posedge core_clk);
    apb(OFS_CONTROL, 1'b0, 0);
    chk("done control", rd, 32'h1B);
    chk("irq raised", irq, 1);
    apb(OFS_STATUS, 1'b0, 0);
    chk("status done", rd, 32'h1);
    apb(OFS_STATUS, 1'b0, 0);
    chk("status cleared", rd, 32'h0);
    chk("irq cleared", irq, 0);
    // load-only fill, a write to the first byte of the page programs it
    apb(OFS_CONTROL, 1'b1, 32'h38);
    mv(1'b1, 8'h44);
    chk("buffer byte", {buf_valid, buf_data}, 9'h144);
    apb(OFS_CONTROL, 1'b0, 0);
    chk("load only idle", rd, 32'h3B);
    apb(OFS_PTR1, 1'b1, 32'h07E0);
    apb(OFS_CONTROL, 1'b1, 32'h1C);
    mv(1'b1, 8'h55);
    chk("page programmed", prog_page, 6'h3F);
    apb(OFS_CONTROL, 1'b1, 32'h18);
    mv(1'b0, 8'h00);
    chk("loaded byte busy", mr, 8'hC4);
    repeat (PROG + 4) @(posedge core_clk);
    apb(OFS_STATUS, 1'b0, 0);
    chk("page done", rd, 32'h1);
    mv(1'b1, 8'h22);
    @(posedge core_clk);
    brownout_detector <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk("inhibit on brownout", write_inhibit_n, 0);
    chk("no reset", cpu_run, 1);
    apb(OFS_STATUS, 1'b0, 0);
    chk("status abort", rd, 32'h6);
    brownout_detector <= 1'b0;
    repeat (BODC - 2) @(posedge core_clk);
    chk("hold-off running", write_inhibit_n, 0);
    repeat (6) @(posedge core_clk);
    chk("hold-off over", write_inhibit_n, 1);
    low_supply <= 1'b1;
    repeat (2) @(posedge core_clk);
    chk("inhibit on low supply", write_inhibit_n, 0);
    mv(1'b1, 8'h66);
    apb(OFS_CONTROL, 1'b0, 0);
    chk("write refused", rd, 32'h1A);
    low_supply <= 1'b0;
    apb(8'h20, 1'b0, 0);
    chk("unmapped err", err, 1);
    chk("unmapped data", rd, 0);
    // mid-run reset restarts the hold-off
    resetn <= 1'b0;
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    apb(OFS_PTR0, 1'b0, 0);
    chk("pointer after reset", rd, 32'h0);
    apb(OFS_CONTROL, 1'b0, 0);
    chk("control after reset", rd, 32'h2);
    chk("run after reset", cpu_run, 1);
    tally_and_finish();
  end
endmodule
